// *** rtl/oex_regs.svh ***
// Constants of the eight-bit output expander link
`ifndef OEX_REGS_SVH
`define OEX_REGS_SVH
// Fixed upper slave address bits
`define OEX_ADDR_FIXED 3'b101
// High select pin codes, address bits 3..2
`define OEX_HI_SCL 2'b00
`define OEX_HI_SDA 2'b01
`define OEX_HI_GND 2'b10
`define OEX_HI_VCC 2'b11
// Low select pin codes, address bits 1..0
`define OEX_LO_GND 2'b00
`define OEX_LO_VCC 2'b01
`define OEX_LO_SCL 2'b10
`define OEX_LO_SDA 2'b11
// Bit counts within a nine-bit frame
`define OEX_LAST_DBIT 4'h7
`define OEX_ACK_BIT 4'h8
// Timing
`define OEX_CLK_NS 100
`define OEX_SCL_NS 2500
`define OEX_QTR_CYC ((`OEX_SCL_NS / 4 + `OEX_CLK_NS - 1) / `OEX_CLK_NS)
`endif

// *** rtl/oex_pkg.sv ***
// Types shared by both ends of the expander link
`include "oex_regs.svh"
package oex_pkg;
  typedef enum logic [1:0] {LS_IDLE, LS_ADDR, LS_WRITE, LS_READ} oex_lphase_t;
  typedef struct packed {
    logic        start_seen;
    oex_lphase_t phase;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic        is_read;
    logic [7:0]  pin_s2;
    logic [7:0]  wr_data;
    logic        wr_tgl;
  } oex_lpos_t;
  typedef struct packed {
    logic       sda_oe;
    logic [7:0] tx_sh;
    logic [7:0] pin_s1;
  } oex_lneg_t;
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       sda_d;
    logic [1:0] hi_s;
    logic [1:0] lo_s;
    logic [1:0] clr_s;
    logic [3:0] mis_prev;
    logic [3:0] ne;
    logic [3:0] own;
    logic [2:0] wt_s;
    logic [7:0] port_out;
  } oex_dsys_t;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} oex_hstate_t;
  typedef struct packed {
    oex_hstate_t st;
    logic [1:0]  q;
    logic [3:0]  qcnt;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic        rd;
    logic        first;
    logic        stop;
    logic [3:0]  left;
    logic        scl;
    logic        sda_oe;
    logic [1:0]  sda_s;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        wr_take;
    logic        ack_err;
    logic        busy;
    logic        cmd_ready;
  } oex_host_t;
endpackage

// *** rtl/oex_if.sv ***
// Two-wire link between bus master and expander
`timescale 1ns/1ps
interface oex_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic sda;
  // Wired-and with pull-up
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_d_oe & ~sda_d_o));
  modport dev (input scl, input sda, output sda_d_o, output sda_d_oe);
  modport host (output scl, output sda_m_o, output sda_m_oe, input sda);
endinterface

// *** rtl/oex_dev.sv ***
// Expander end: two-wire slave driving eight output lines
//
// What this block does
// R01: Answer only address 101 plus pin bits
// R02: Each select pin has four levels
// R03: Re-decode select pins on every transmission
// R04: Before first transmission pins read static
// R05: Power-up outputs preset from select pins
// R06: One byte loads all eight outputs
// R07: Start and stop while clock high
// R08: One bit per clock, stable while high
// R09: Ninth clock carries a low acknowledge
// R10: Receiver drives acknowledge
// R11: Start, address, direction, bytes, stop
// R12: Read returns pin levels sampled at acknowledge
// R13: Resample pins at every read acknowledge
// R14: Write address acknowledge also samples pins
// R15: Acknowledge and apply every written byte
// R16: Data open-drain pull-low, clock input only
// R17: Master starts transfers, makes all clocks
// R18: Bus clear aborts, keeps output latch
// R19: High pin bits 3..2, low pin 1..0
// R20: Address mismatch: release data, wait start
`timescale 1ns/1ps
`include "oex_regs.svh"
module oex_dev (
  // Link
  oex_if.dev         link,
  input  logic       bus_clear_n,
  // System
  input  logic       clk,
  input  logic       srst,
  // Address select pins
  input  logic       addr_select_low_pin,
  input  logic       addr_select_high_pin,
  // Port lines
  input  logic [7:0] port_pin_levels,
  output logic [7:0] output_port_lines
);
  import oex_pkg::*;

  oex_lpos_t pr;
  oex_lpos_t pn;
  oex_lneg_t ng_r;
  oex_lneg_t ng_n;
  oex_dsys_t sr;
  oex_dsys_t sn;
  logic      start_tgl_r;
  logic      start_c;
  logic [3:0] mis;

  // ==========================================================
  // Select pin decode
  function automatic logic [1:0] hi_code(input logic ne_scl,
                                         input logic ne_sda,
                                         input logic lvl);
    if (!ne_sda)
      return `OEX_HI_SDA;
    else if (!ne_scl)
      return `OEX_HI_SCL;
    else
      return lvl ? `OEX_HI_VCC : `OEX_HI_GND;
  endfunction

  function automatic logic [1:0] lo_code(input logic ne_scl,
                                         input logic ne_sda,
                                         input logic lvl);
    if (!ne_sda)
      return `OEX_LO_SDA;
    else if (!ne_scl)
      return `OEX_LO_SCL;
    else
      return lvl ? `OEX_LO_VCC : `OEX_LO_GND;
  endfunction

  // ==========================================================
  // Start detect on data falling edge
  // A toggle, not a pulse: it is read at the next rising clock
  always_ff @(negedge link.sda or negedge bus_clear_n) begin
    if (!bus_clear_n)
      start_tgl_r <= 1'b0;
    else if (link.scl)
      start_tgl_r <= ~start_tgl_r; // see R07
  end

  // ==========================================================
  // Link receive side, rising clock
  always_comb begin
    pn = pr;
    pn.pin_s2 = ng_r.pin_s1;
    // New start restarts the frame whatever came before
    if (start_tgl_r != pr.start_seen) begin
      pn.start_seen = start_tgl_r;
      pn.phase = LS_ADDR; // see R11
      pn.bitcnt = 4'h1;
      pn.shreg = {7'h00, link.sda};
    end else if (pr.phase != LS_IDLE) begin
      if (pr.bitcnt != `OEX_ACK_BIT) begin
        pn.shreg = {pr.shreg[6:0], link.sda}; // see R08
        pn.bitcnt = pr.bitcnt + 4'h1;
        if (pr.phase == LS_ADDR && pr.bitcnt == `OEX_LAST_DBIT) begin
          pn.is_read = link.sda;
          // Own address is settled before its low bits arrive
          if (pr.shreg[6:0] != {`OEX_ADDR_FIXED, sr.own})
            pn.phase = LS_IDLE; // see R01, R20
        end
        if (pr.phase == LS_WRITE && pr.bitcnt == `OEX_LAST_DBIT) begin
          pn.wr_data = {pr.shreg[6:0], link.sda}; // see R06, R15
          pn.wr_tgl = ~pr.wr_tgl;
        end
      end else begin
        // Acknowledge clock: enter the data phase or end a read
        pn.bitcnt = 4'h0;
        case (pr.phase)
          LS_ADDR:
            pn.phase = pr.is_read ? LS_READ : LS_WRITE;
          LS_READ:
            if (link.sda)
              pn.phase = LS_IDLE; // see R10
          default: ;
        endcase
      end
    end
  end

  // Bus clear resets the frame but not the output latch
  always_ff @(posedge link.scl or negedge bus_clear_n) begin
    if (!bus_clear_n)
      pr <= '0; // see R18
    else
      pr <= pn;
  end

  // ==========================================================
  // Link drive side, falling clock
  always_comb begin
    ng_n = ng_r;
    ng_n.pin_s1 = port_pin_levels; // see R12, R14
    ng_n.sda_oe = 1'b0;
    // Acknowledge pulled from the fall after the eighth bit
    if (pr.bitcnt == `OEX_ACK_BIT &&
        (pr.phase == LS_ADDR || pr.phase == LS_WRITE)) begin
      ng_n.sda_oe = 1'b1; // see R09, R10, R15
    end else if (pr.phase == LS_READ && pr.bitcnt != `OEX_ACK_BIT) begin
      if (pr.bitcnt == 4'h0) begin
        // Fresh pin sample taken during the acknowledge
        ng_n.sda_oe = ~pr.pin_s2[7]; // see R12, R13
        ng_n.tx_sh = {pr.pin_s2[6:0], 1'b0};
      end else begin
        ng_n.sda_oe = ~ng_r.tx_sh[7]; // see R08
        ng_n.tx_sh = {ng_r.tx_sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(negedge link.scl or negedge bus_clear_n) begin
    if (!bus_clear_n)
      ng_r <= '0; // see R18
    else
      ng_r <= ng_n;
  end

  // Pull-low only; clock never driven
  assign link.sda_d_o = 1'b0; // see R16
  assign link.sda_d_oe = ng_r.sda_oe;

  // ==========================================================
  // System side: pin classing and output latch
  always_comb begin
    sn = sr;
    sn.scl_s = {sr.scl_s[0], link.scl};
    sn.sda_s = {sr.sda_s[0], link.sda};
    sn.hi_s = {sr.hi_s[0], addr_select_high_pin};
    sn.lo_s = {sr.lo_s[0], addr_select_low_pin};
    sn.clr_s = {sr.clr_s[0], bus_clear_n};
    sn.wt_s = {sr.wt_s[1:0], pr.wr_tgl};
    sn.sda_d = sr.sda_s[1];
    start_c = sr.sda_d & ~sr.sda_s[1] & sr.scl_s[1];
    // A pin tied to a bus line never drifts from it
    mis = {sr.hi_s[1] != sr.scl_s[1], sr.hi_s[1] != sr.sda_s[1],
           sr.lo_s[1] != sr.scl_s[1], sr.lo_s[1] != sr.sda_s[1]};
    sn.mis_prev = mis;
    // Two-cycle mismatch filters sync skew
    if (start_c)
      sn.ne = 4'h0; // see R03
    else
      sn.ne = sr.ne | (mis & sr.mis_prev); // see R02
    // Class each pin by what it has disagreed with
    sn.own = {hi_code(sr.ne[3], sr.ne[2], sr.hi_s[1]),
              lo_code(sr.ne[1], sr.ne[0], sr.lo_s[1])}; // see R19
    // Writes ignored while bus clear realigns the toggle
    if ((sr.wt_s[2] ^ sr.wt_s[1]) && sr.clr_s[1])
      sn.port_out = pr.wr_data; // see R06, R15
    // Power-up preset; pin ties still read as plain levels
    if (srst) begin
      sn.ne = 4'hf; // see R04
      sn.mis_prev = 4'h0;
      sn.port_out = {{4{sr.hi_s[1]}}, {4{sr.lo_s[1]}}}; // see R05
    end
  end

  always_ff @(posedge clk) begin
    sr <= sn;
  end

  assign output_port_lines = sr.port_out;

endmodule // oex_dev

// *** rtl/oex_host.sv ***
// Master end: two-wire bus master issuing expander transfers
`timescale 1ns/1ps
`include "oex_regs.svh"
module oex_host (
  // System
  input  logic       clk,
  input  logic       srst,
  // Command
  input  logic       cmd_valid,
  input  logic       cmd_read,
  input  logic [6:0] cmd_addr,
  input  logic [3:0] cmd_len,
  output logic       cmd_ready,
  // Write data
  input  logic [7:0] wr_data,
  output logic       wr_take,
  // Read data and status
  output logic [7:0] rd_data,
  output logic       rd_valid,
  output logic       busy,
  output logic       ack_err,
  // Link
  oex_if.host        link
);
  import oex_pkg::*;

  localparam logic [3:0] QTR_LAST = 4'(`OEX_QTR_CYC - 1);

  oex_host_t r;
  oex_host_t n;
  logic      tick;
  logic      rx;
  logic      sd;
  logic [1:0] nq;

  // ==========================================================
  // Quarter-bit sequencer
  always_comb begin
    n = r;
    n.rd_valid = 1'b0;
    n.wr_take = 1'b0;
    n.sda_s = {r.sda_s[0], link.sda};
    sd = r.sda_s[1];
    tick = (r.qcnt == QTR_LAST);
    nq = r.q + 2'd1;
    n.qcnt = tick ? 4'h0 : r.qcnt + 4'h1;
    rx = r.rd & ~r.first;
    case (r.st)
      HS_IDLE: begin
        n.qcnt = 4'h0;
        n.q = 2'd0;
        if (cmd_valid) begin
          n.st = HS_START; // see R17
          n.sh = {cmd_addr, cmd_read}; // see R11
          n.rd = cmd_read;
          n.left = cmd_len;
          n.first = 1'b1;
          n.stop = 1'b0;
          n.busy = 1'b1;
          n.cmd_ready = 1'b0;
          n.ack_err = 1'b0;
        end
      end
      HS_START: if (tick) begin
        n.q = nq;
        case (nq)
          2'd2: n.sda_oe = 1'b1; // see R07
          2'd3: n.scl = 1'b0;
          2'd0: begin
            n.st = HS_BIT;
            n.bitn = 4'h0;
            n.sda_oe = ~r.sh[7];
          end
          default: ;
        endcase
      end
      HS_BIT: if (tick) begin
        n.q = nq;
        case (nq)
          2'd1: n.scl = 1'b1;
          2'd3: begin
            n.scl = 1'b0;
            if (r.bitn != `OEX_ACK_BIT) begin
              n.sh = {r.sh[6:0], rx & sd}; // see R08
            end else if (!rx && sd) begin
              n.ack_err = 1'b1;
              n.stop = 1'b1;
            end else if (r.first) begin
              n.first = 1'b0;
              if (!r.rd) begin
                n.sh = wr_data;
                n.wr_take = 1'b1;
              end
            end else begin
              n.left = r.left - 4'h1;
              if (r.left == 4'h1) begin
                n.stop = 1'b1;
              end else if (!r.rd) begin
                n.sh = wr_data;
                n.wr_take = 1'b1;
              end
              if (rx) begin
                n.rd_data = r.sh;
                n.rd_valid = 1'b1;
              end
            end
          end
          2'd0: begin
            if (r.bitn == `OEX_ACK_BIT) begin
              if (r.stop) begin
                n.st = HS_STOP;
                n.sda_oe = 1'b1;
              end else begin
                n.bitn = 4'h0;
                n.sda_oe = rx ? 1'b0 : ~r.sh[7];
              end
            end else begin
              n.bitn = r.bitn + 4'h1;
              // Ack all read bytes but the last
              if (r.bitn == `OEX_LAST_DBIT)
                n.sda_oe = rx & (r.left != 4'h1); // see R09, R10
              else
                n.sda_oe = rx ? 1'b0 : ~r.sh[7];
            end
          end
          default: ;
        endcase
      end
      HS_STOP: if (tick) begin
        n.q = nq;
        case (nq)
          2'd1: n.scl = 1'b1;
          2'd2: n.sda_oe = 1'b0; // see R07
          2'd0: begin
            n.st = HS_IDLE;
            n.busy = 1'b0;
            n.cmd_ready = 1'b1;
          end
          default: ;
        endcase
      end
      default: n.st = HS_IDLE;
    endcase
    if (srst) begin
      n = '0;
      n.scl = 1'b1;
      n.cmd_ready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  assign link.scl = r.scl;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = r.sda_oe;
  assign cmd_ready = r.cmd_ready;
  assign wr_take = r.wr_take;
  assign rd_data = r.rd_data;
  assign rd_valid = r.rd_valid;
  assign busy = r.busy;
  assign ack_err = r.ack_err;

endmodule // oex_host

// *** verification/oex_link_sva.sv ***
// Concurrent checks on the expander two-wire link
`timescale 1ns/1ps
module oex_link_sva (
  // System
  input wire logic clk,
  input wire logic srst,
  input wire logic bus_clear_n,
  // Link
  input wire logic scl,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic sda
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================
  // Link checks
  pull_only_a: assert property (!sda_d_o && !sda_m_o)
    else $error("data line driven high by an end");
  dev_edge_a: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device data moved while clock high");
  stable_high_a: assert property ($rose(scl) |=> $stable(sda) [*5])
    else $error("data moved during clock high");
  // Hand-over overlap is legal only while the clock is low
  no_fight_a: assert property (sda_d_oe && sda_m_oe |-> !scl)
    else $error("both ends pull data while clock high");
  idle_high_a: assert property ($fell(srst) |-> scl && sda)
    else $error("link not idle high after reset");
  start_form_a: assert property (
    $fell(sda) && scl |-> scl [*5] ##[1:4] !scl)
    else $error("start not followed by clock low");
  stop_form_a: assert property ($rose(sda) && scl |-> scl [*6])
    else $error("clock not idle after stop");
  scl_low_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  clear_rel_a: assert property (
    !bus_clear_n |-> ##[0:2] !sda_d_oe)
    else $error("bus clear did not release data");
endmodule // oex_link_sva

// *** verification/tb_i2c_eight_bit_output_expander.sv ***
// Self-checking bench joining master end and expander end
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_i2c_eight_bit_output_expander;
  import oex_pkg::*;
  logic       clk, srst, bus_clear_n, cmd_valid, cmd_read, cmd_ready;
  logic       wr_take, rd_valid, busy, ack_err, pin_hi, pin_lo;
  logic [6:0] cmd_addr;
  logic [3:0] cmd_len, own, lv;
  logic [7:0] wr_data, rd_data, out_lines, pins, mask, b;
  logic [1:0] sel_hi, sel_lo, wr_idx;
  logic [7:0] wbuf [4];
  logic [7:0] rq [$];
  int         fails, n_checks, cyc;
  // Select codes by tie: ground, supply, clock, data
  localparam logic [1:0] HI_C [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
  localparam logic [1:0] LO_C [4] = '{2'b00, 2'b01, 2'b10, 2'b11};

  oex_if oex_if_inst ();
  assign lv      = {oex_if_inst.sda, oex_if_inst.scl, 1'b1, 1'b0};
  assign pin_hi  = lv[sel_hi];
  assign pin_lo  = lv[sel_lo];
  assign pins    = out_lines ^ mask;
  assign wr_data = wbuf[wr_idx];

  oex_dev oex_dev_inst (.link(oex_if_inst), .bus_clear_n(bus_clear_n),
    .clk(clk), .srst(srst), .addr_select_low_pin(pin_lo),
    .addr_select_high_pin(pin_hi), .port_pin_levels(pins),
    .output_port_lines(out_lines));
  oex_host oex_host_inst (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .cmd_ready(cmd_ready), .wr_data(wr_data), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
    .ack_err(ack_err), .link(oex_if_inst));
  oex_link_sva oex_link_sva_inst (.clk(clk), .srst(srst),
    .bus_clear_n(bus_clear_n), .scl(oex_if_inst.scl),
    .sda_m_o(oex_if_inst.sda_m_o), .sda_m_oe(oex_if_inst.sda_m_oe),
    .sda_d_o(oex_if_inst.sda_d_o), .sda_d_oe(oex_if_inst.sda_d_oe),
    .sda(oex_if_inst.sda));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================
  // Data feed, read capture and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr_take === 1'b1) wr_idx <= wr_idx + 2'd1;
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (cyc == 60000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic xfer(input logic r, input logic [6:0] a,
                      input logic [3:0] n);
    cmd_read  <= r;
    cmd_addr  <= a;
    cmd_len   <= n;
    cmd_valid <= 1'b1;
    wr_idx    <= 2'd0;
    @(posedge clk);
    while (cmd_ready !== 1'b1) @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge clk);
    while (cmd_ready !== 1'b1) @(posedge clk);
  endtask

  // Waits into the first data byte of a transfer
  task automatic mid_frame();
    repeat (12) @(negedge oex_if_inst.scl);
    @(posedge clk);
  endtask

  // ==========================================
  // Test sequence
  initial begin
    srst = 1'b1;
    bus_clear_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 7'h00;
    cmd_len = 4'h0;
    sel_hi = 2'd0;
    sel_lo = 2'd2;
    mask = 8'h00;
    wr_idx = 2'd0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    bus_clear_n <= 1'b1;
    @(posedge clk);
    `CHK(out_lines, 8'h0f)
    $display("test power-up done");
    for (int i = 0; i < 16; i++) begin
      sel_hi <= i[3:2];
      sel_lo <= i[1:0];
      own = {HI_C[i[3:2]], LO_C[i[1:0]]};
      b = {i[3:0], ~i[3:0]};
      wbuf[0] <= b;
      xfer(1'b0, {3'b101, own}, 4'd1);
      `CHK(ack_err, 1'b0)
      `CHK(out_lines, b)
    end
    $display("test address map done");
    for (int k = 0; k < 2; k++) begin
      wbuf[0] <= 8'h5a;
      xfer(1'b0, k ? {3'b101, own ^ 4'h1} : {3'b110, own}, 4'd1);
      `CHK(ack_err, 1'b1)
      `CHK(out_lines, b)
    end
    $display("test foreign address done");
    wbuf[0] <= 8'h12;
    wbuf[1] <= 8'hc3;
    wbuf[2] <= 8'h7e;
    xfer(1'b0, {3'b101, own}, 4'd3);
    `CHK(ack_err, 1'b0)
    `CHK(out_lines, 8'h7e)
    `CHK(busy, 1'b0)
    $display("test multibyte write done");
    rq = {};
    mask <= 8'h81;
    fork
      xfer(1'b1, {3'b101, own}, 4'd2);
      begin
        mid_frame();
        mask <= 8'h18;
      end
    join
    `CHK(rq[0], 8'hff)
    `CHK(rq[1], 8'h66)
    `CHK(rq.size(), 2)
    mask <= 8'h00;
    $display("test read back done");
    wbuf[0] <= 8'h00;
    fork
      xfer(1'b0, {3'b101, own}, 4'd1);
      begin
        mid_frame();
        bus_clear_n <= 1'b0;
        repeat (4) @(posedge clk);
        bus_clear_n <= 1'b1;
      end
    join
    `CHK(ack_err, 1'b1)
    `CHK(out_lines, 8'h7e)
    wbuf[0] <= 8'ha5;
    xfer(1'b0, {3'b101, own}, 4'd1);
    `CHK(out_lines, 8'ha5)
    $display("test bus clear done");
    final_report();
  end
endmodule // tb_i2c_eight_bit_output_expander
